// ---- core/hardware_watchdog_timer.sv ----
module hardware_watchdog_timer
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic MACHINE_CYCLE,
  input wire logic PERIPH_CLOCK_TICK,
  input wire logic POWER_DOWN,
  input wire logic EXT_INT_N,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WRITE,
  input wire logic SFR_READ,
  output logic [7:0] SFR_RDATA,
  output logic WATCHDOG_ACTIVE,
  output logic RST_OUT_N
);
  watchdog_pkg::key_state_t key_q;
  logic enabled_q;
  logic [watchdog_pkg::PRESCALE_WIDTH-1:0] prescale_q;
  logic [watchdog_pkg::COUNT_WIDTH-1:0] count_q;
  logic [watchdog_pkg::SELECT_WIDTH-1:0] select_q;
  logic [6:0] pulse_cnt_q;
  logic pulse_q;
  logic [7:0] rdata_q;
  logic int_s1_q;
  logic int_s2_q;
  logic int_s3_q;
  logic int_high_q;
  logic pd_hold_q;
  logic key_write;
  logic service;
  logic run;
  logic [watchdog_pkg::PRESCALE_WIDTH-1:0] tick_mask;
  logic count_tick;
  logic overflow;

  // Decode of key writes
  assign key_write = SFR_WRITE && (SFR_ADDR == watchdog_pkg::RESTART_KEY_ADDR);
  assign service = key_write && (key_q == watchdog_pkg::KEY_GOT_FIRST)
                   && (SFR_WDATA == watchdog_pkg::KEY_SECOND);

  // Key sequence tracker; any other byte drops back to idle
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      key_q <= watchdog_pkg::KEY_IDLE;
    end
    else if (key_write)
    begin
      if (SFR_WDATA == watchdog_pkg::KEY_FIRST)
      begin
        key_q <= watchdog_pkg::KEY_GOT_FIRST;
      end
      else
      begin
        key_q <= watchdog_pkg::KEY_IDLE;
      end
    end
  end

  // Enable is one-way: only reset or our own overflow clears it
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      enabled_q <= 1'b0;
    end
    else if (overflow)
    begin
      enabled_q <= 1'b0;
    end
    else if (service)
    begin
      enabled_q <= 1'b1;
    end
  end

  // Wake pin: three stages, level accepted when last two agree
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      int_s1_q <= 1'b1;
      int_s2_q <= 1'b1;
      int_s3_q <= 1'b1;
      int_high_q <= 1'b1;
    end
    else
    begin
      int_s1_q <= EXT_INT_N;
      int_s2_q <= int_s1_q;
      int_s3_q <= int_s2_q;
      if (int_s2_q == int_s3_q)
      begin
        int_high_q <= int_s3_q;
      end
    end
  end

  // Hold off counting after power-down until the wake pin is high again
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      pd_hold_q <= 1'b0;
    end
    else if (POWER_DOWN)
    begin
      pd_hold_q <= 1'b1;
    end
    else if (int_high_q)
    begin
      pd_hold_q <= 1'b0;
    end
  end

  // Oscillator stopped in power-down, so prescaler and counter hold
  assign run = enabled_q && MACHINE_CYCLE && !POWER_DOWN && !pd_hold_q;

  // Counter steps once every 2^select machine cycles
  assign tick_mask = watchdog_pkg::PRESCALE_WIDTH'((8'h01 << select_q) - 8'h01);
  assign count_tick = run && ((prescale_q & tick_mask) == tick_mask);
  assign overflow = enabled_q && (count_q == watchdog_pkg::COUNT_TERMINAL);

  // Prescaler and counter, both restarted by each full key sequence
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      prescale_q <= '0;
      count_q <= '0;
    end
    else if (service || overflow)
    begin
      prescale_q <= '0;
      count_q <= '0;
    end
    else if (run)
    begin
      prescale_q <= prescale_q + 1'b1;
      if (count_tick)
      begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // Reset pulse stretched over peripheral clock periods
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      pulse_q <= 1'b0;
      pulse_cnt_q <= '0;
    end
    else if (overflow)
    begin
      pulse_q <= 1'b1;
      pulse_cnt_q <= '0;
    end
    else if (pulse_q && PERIPH_CLOCK_TICK)
    begin
      if (pulse_cnt_q == 7'(watchdog_pkg::RESET_PULSE_PERIODS - 1))
      begin
        pulse_q <= 1'b0;
      end
      pulse_cnt_q <= pulse_cnt_q + 1'b1;
    end
  end

  // Timeout select register; upper bits are not stored
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      select_q <= watchdog_pkg::SELECT_RESET;
    end
    else if (SFR_WRITE && (SFR_ADDR == watchdog_pkg::TIMEOUT_SELECT_ADDR))
    begin
      select_q <= SFR_WDATA[watchdog_pkg::SELECT_WIDTH-1:0];
    end
  end

  // Read path: key register and count are never visible
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      rdata_q <= 8'h00;
    end
    else if (SFR_READ && (SFR_ADDR == watchdog_pkg::TIMEOUT_SELECT_ADDR))
    begin
      rdata_q <= {5'h00, select_q};
    end
    else
    begin
      rdata_q <= 8'h00;
    end
  end

  // Registered outputs
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      RST_OUT_N <= 1'b1;
      WATCHDOG_ACTIVE <= 1'b0;
    end
    else
    begin
      RST_OUT_N <= !(pulse_q || overflow);
      WATCHDOG_ACTIVE <= enabled_q && !overflow;
    end
  end

  assign SFR_RDATA = rdata_q;
endmodule : hardware_watchdog_timer

// ---- core/watchdog_pkg.sv ----
// Notes on behaviour
// - Inactive after any reset until keyed
// - Enable by writing 1E then E1
// - Repeat key sequence before overflow
// - Count advances every 2^select machine cycles once enabled
// - No disable except reset or overflow
// - 14-bit counter overflows at 16383
// - Overflow drives reset low 96 peripheral clocks
// - Key register write-only, count unreachable
// - 2^7 prescaler extends the timeout
// - Timeout select resets to zero
// - Count freezes during power-down
// - Wake by interrupt waits for pin high
package watchdog_pkg;
  localparam logic [7:0] RESTART_KEY_ADDR = 8'hA6;
  localparam logic [7:0] TIMEOUT_SELECT_ADDR = 8'hA7;
  localparam logic [7:0] KEY_FIRST = 8'h1E;
  localparam logic [7:0] KEY_SECOND = 8'hE1;
  localparam int COUNT_WIDTH = 14;
  localparam logic [13:0] COUNT_TERMINAL = 14'h3FFF;
  localparam int PRESCALE_WIDTH = 7;
  localparam int SELECT_WIDTH = 3;
  localparam logic [2:0] SELECT_RESET = 3'h0;
  localparam int RESET_PULSE_PERIODS = 96;

  typedef enum logic [0:0]
  {
    KEY_IDLE = 1'b0,
    KEY_GOT_FIRST = 1'b1
  } key_state_t;
endpackage : watchdog_pkg

// ---- verification/hardware_watchdog_timer_chk.sv ----
module hardware_watchdog_timer_chk
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic PERIPH_CLOCK_TICK,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WRITE,
  input wire logic SFR_READ,
  input wire logic [7:0] SFR_RDATA,
  input wire logic WATCHDOG_ACTIVE,
  input wire logic RST_OUT_N
);
  logic [7:0] ticks_q;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  // Ticks seen while the pulse is low
  always_ff @(posedge MCLK)
  begin
    if (RST_OUT_N)
      ticks_q <= 8'h00;
    else
      ticks_q <= ticks_q + {7'h00, PERIPH_CLOCK_TICK};
  end
  chk_key_read:
  assert property (SFR_READ && SFR_ADDR == 8'hA6 |=> SFR_RDATA == 8'h00) else $error("key read");
  chk_sel_read:
  assert property (SFR_READ && SFR_ADDR == 8'hA7 |=> SFR_RDATA[7:3] == 5'h00) else $error("sel");
  chk_rdata_idle:
  assert property (!SFR_READ |=> SFR_RDATA == 8'h00) else $error("rdata idle");
  chk_key_enable:
  assert property (SFR_WRITE && SFR_ADDR == 8'hA6 && SFR_WDATA == 8'hE1
    && $past(SFR_WRITE && SFR_WDATA == 8'h1E) |=> ##1 WATCHDOG_ACTIVE) else $error("enable");
  chk_no_disable:
  assert property (WATCHDOG_ACTIVE && RST_OUT_N |=> WATCHDOG_ACTIVE || !RST_OUT_N) else $error("off");
  chk_idle_quiet:
  assert property (!WATCHDOG_ACTIVE && RST_OUT_N |=> RST_OUT_N) else $error("idle reset");
  chk_fall_cause:
  assert property ($fell(RST_OUT_N) |-> $past(WATCHDOG_ACTIVE)) else $error("stray reset");
  chk_pulse_len:
  assert property ($rose(RST_OUT_N) |-> ticks_q >= 8'h5F && ticks_q <= 8'h61) else $error("pulse");
endmodule : hardware_watchdog_timer_chk
bind hardware_watchdog_timer hardware_watchdog_timer_chk chk_u (.*);

// ---- verification/hardware_watchdog_timer_tb.sv ----
module hardware_watchdog_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK = 0, RESET_N = 0, PERIPH_CLOCK_TICK = 0, SFR_WRITE = 0, SFR_READ = 0, rd_q = 0;
  logic [7:0] SFR_ADDR = 0, SFR_WDATA = 0, SFR_RDATA, exp_q[$];
  logic WATCHDOG_ACTIVE, RST_OUT_N;
  logic POWER_DOWN = 0, EXT_INT_N = 1;
  logic [7:0] r;
  int error_cnt = 0, compares = 0, n;
  // Machine-cycle strobe tied high: shortest run, one count per clock
  hardware_watchdog_timer dut_u (.*, .MACHINE_CYCLE(1'b1));
  always #10 MCLK = ~MCLK;
  // Peripheral tick every second cycle
  always @(posedge MCLK) PERIPH_CLOCK_TICK <= ~PERIPH_CLOCK_TICK;
  task automatic chk(string s, logic [7:0] g, e);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // One access; a read notes its expected data
  task automatic acc(logic w, logic [7:0] a, d);
    @(posedge MCLK);
    SFR_WRITE <= w;
    SFR_READ <= !w;
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    if (!w)
      exp_q.push_back(d);
    @(posedge MCLK);
    SFR_WRITE <= 0;
    SFR_READ <= 0;
  endtask : acc
  // Key bytes with one idle cycle between them
  task automatic key();
    acc(1, 8'hA6, 8'h1E);
    @(posedge MCLK);
    SFR_WRITE <= 1;
    SFR_WDATA <= 8'hE1;
    @(posedge MCLK);
    SFR_WRITE <= 0;
  endtask : key
  // Read data is taken the cycle after the strobe
  always @(posedge MCLK)
  begin
    rd_q <= SFR_READ;
    if (rd_q)
      chk("rdata", SFR_RDATA, exp_q.pop_front());
  end
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Hang guard, well past the expected run
  initial
  begin
    #1500us;
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(4));
    repeat (6) @(posedge MCLK);
    RESET_N <= 1;
    acc(0, 8'hA7, 8'h00);
    acc(0, 8'hA6, 8'h00);
    acc(1, 8'hA6, 8'h1E);
    acc(1, 8'hA6, 8'h55);
    acc(1, 8'h80, 8'($urandom));
    acc(1, 8'hA6, 8'hE1);
    repeat (3) @(posedge MCLK);
    chk("active", {7'h00, WATCHDOG_ACTIVE}, 8'h00);
    $display("test done: broken key");
    key();
    repeat (3) @(posedge MCLK);
    chk("active", {7'h00, WATCHDOG_ACTIVE}, 8'h01);
    repeat (12000) @(posedge MCLK);
    key();
    n = 0;
    while (RST_OUT_N === 1'b1 && n < 17000)
    begin
      @(posedge MCLK);
      n++;
    end
    chk("timeout", 8'(n >= 16375 && n <= 16395), 8'h01);
    n = 0;
    while (RST_OUT_N !== 1'b1 && n < 1000)
    begin
      @(posedge MCLK);
      n++;
    end
    chk("pulse", 8'(n >= 188 && n <= 196), 8'h01);
    chk("active", {7'h00, WATCHDOG_ACTIVE}, 8'h00);
    $display("test done: service and overflow");
    // Frozen in power-down, held while wake pin is low
    key();
    repeat (16000) @(posedge MCLK);
    POWER_DOWN <= 1;
    repeat (1000) @(posedge MCLK);
    EXT_INT_N <= 0;
    repeat (1000) @(posedge MCLK);
    POWER_DOWN <= 0;
    repeat (1000) @(posedge MCLK);
    chk("pd hold", {7'h00, RST_OUT_N}, 8'h01);
    EXT_INT_N <= 1;
    n = 0;
    while (RST_OUT_N === 1'b1 && n < 1000)
    begin
      @(posedge MCLK);
      n++;
    end
    chk("pd resume", 8'(n >= 380 && n <= 400), 8'h01);
    $display("test done: power-down freeze");
    // Timeout select readback, reserved bits read zero
    r = 8'($urandom);
    acc(1, 8'hA7, r);
    acc(0, 8'hA7, {5'h00, r[2:0]});
    repeat (2) @(posedge MCLK);
    $display("test done: select readback");
    give_verdict();
  end
endmodule : hardware_watchdog_timer_tb
